// *** rtl/sbt_master.sv ***
// master end of the shared bus port, with the snoop side of an owning cache
// assumes a central arbiter and one addressed slave on the far side of sbt_bus_if
`timescale 1ns/1ps
module sbt_master #(
  parameter int BEAT_W = 3
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // bus
  sbt_bus_if.master bus,
  // request
  input wire logic req_valid_i,
  output logic req_ready_o,
  input wire logic req_write_i,
  input wire logic req_coherent_i,
  input wire logic [sbt_pkg::ADDR_W-1:0] req_addr_i,
  input wire logic [sbt_pkg::CTRL_W-1:0] req_ctrl_i,
  input wire logic [sbt_pkg::SIZE_W-1:0] req_size_i,
  input wire logic [BEAT_W-1:0] req_beats_i,
  input wire logic hold_bus_i,
  // write data
  input wire logic [sbt_pkg::DATA_W-1:0] wr_data_i,
  output logic [BEAT_W-1:0] wr_beat_o,
  // read data and completion
  output logic rsp_valid_o,
  output logic [sbt_pkg::DATA_W-1:0] rsp_data_o,
  output logic rsp_flush_o,
  output logic done_o,
  output sbt_pkg::sbt_ack_t done_ack_o,
  // snoop
  output logic snoop_valid_o,
  output logic [sbt_pkg::ADDR_W-1:0] snoop_addr_o,
  input wire logic snoop_own_i
);
  import sbt_pkg::*;

  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_REQ = 3'h1,
    ST_ADDR = 3'h3,
    ST_DATA = 3'h2,
    ST_HOLD = 3'h6
  } sbt_mst_st_t;

  sbt_mst_st_t st_q, st_d, end_st;
  logic [ADDR_W-1:0] addr_q;
  logic [CTRL_W-1:0] ctrl_q;
  logic [SIZE_W-1:0] size_q;
  logic [BEAT_W-1:0] beats_q, beat_q, wbeat_q;
  logic write_q, coh_q, mih_seen_q, mih_drv_q;
  logic [1:0] acnt_q, park_q;
  logic [DATA_W-1:0] mad_q;
  sbt_ack_t ack;
  logic ack_data, ack_term, granted, accept, in_txn, mih_win, mih_hit;
  logic acc_beat, last_beat, restart, finish;
  logic [5:0] shift;
  logic [DATA_W-1:0] rmask;

  // ==========================================================
  // acknowledge and arbitration view
  sbt_ack_decode sbt_ack_decode_inst (
    .ack_n_i(bus.ack_n),
    .ack_o(ack),
    .data_o(ack_data),
    .term_o(ack_term)
  );

  assign granted = ~bus.s_mbg_n & bus.mbb_n;
  assign accept = req_valid_i & req_ready_o;
  assign req_ready_o = (st_q == ST_IDLE) || (st_q == ST_HOLD);
  assign in_txn = (st_q == ST_DATA);
  assign shift = sbt_lane_shift(addr_q[2:0], size_q);
  // bytes past the transfer size are cleared, so stray lanes never reach the user
  assign rmask = ~({DATA_W{1'b1}} << (7'h8 << size_q));
  // inhibit is honoured from A+2 until the ack; counter saturates at 2
  assign mih_win = in_txn & coh_q & (acnt_q == 2'(MIH_A_CYC));
  assign mih_hit = mih_win & ~bus.mih_n & ~mih_seen_q;
  // a ready in the inhibit cycle came from memory and is dropped
  assign acc_beat = in_txn & ack_data & ~(mih_win & ~bus.mih_n);
  assign last_beat = acc_beat & (BEAT_W'(beat_q + 1'b1) == beats_q);
  assign restart = (ack == ACK_RR) || (ack == ACK_RETRY);
  assign finish = in_txn & ((ack_term & ~restart) | last_beat);
  // keep the bus only while the grant stays parked here
  assign end_st = (hold_bus_i & ~bus.s_mbg_n) ? ST_HOLD : ST_IDLE;

  // ==========================================================
  // transaction sequencer
  always_comb begin
    st_d = st_q;
    unique case (st_q)
      ST_IDLE: begin
        if (req_valid_i) begin
          st_d = granted ? ST_ADDR : ST_REQ;
        end
      end
      ST_REQ: begin
        if (granted) begin
          st_d = ST_ADDR;
        end
      end
      ST_ADDR: begin
        st_d = ST_DATA;
      end
      ST_DATA: begin
        if (ack_term) begin
          // both retry kinds go back to arbitration and reissue later
          st_d = restart ? ST_REQ : end_st;
        end else if (last_beat) begin
          st_d = end_st;
        end
      end
      ST_HOLD: begin
        if (req_valid_i && !bus.s_mbg_n) begin
          st_d = ST_ADDR;
        end else if (~hold_bus_i || bus.s_mbg_n || park_q == 2'(PARK_MAX_CYC - 1)) begin
          st_d = ST_IDLE;
        end
      end
      default: st_d = ST_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      st_q <= ST_IDLE;
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================
  // request capture, kept for reissue after retry
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      addr_q <= '0;
      ctrl_q <= '0;
      size_q <= '0;
      beats_q <= '0;
      write_q <= 1'b0;
      coh_q <= 1'b0;
    end else if (accept) begin
      addr_q <= req_addr_i;
      ctrl_q <= req_ctrl_i;
      size_q <= req_size_i;
      beats_q <= req_beats_i;
      write_q <= req_write_i;
      coh_q <= req_coherent_i & ~req_write_i;
    end
  end

  // ==========================================================
  // address and write data on the multiplexed lines
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      mad_q <= '0;
      wbeat_q <= '0;
    end else if (st_d == ST_ADDR && st_q != ST_ADDR) begin
      if (accept) begin
        mad_q <= {req_ctrl_i, req_addr_i};
      end else begin
        mad_q <= {ctrl_q, addr_q};
      end
      wbeat_q <= '0;
    end else if ((st_q == ST_ADDR) || (acc_beat && write_q && !last_beat)) begin
      // right-justified data moved to its lanes, other lanes zero
      mad_q <= (wr_data_i & rmask) << shift;
      wbeat_q <= BEAT_W'(wbeat_q + 1'b1);
    end
  end

  assign wr_beat_o = wbeat_q;
  assign bus.m_mad_o = mad_q;
  assign bus.m_mad_oe = (st_q == ST_ADDR) || (in_txn && write_q);
  assign bus.m_mas_oe = (st_q == ST_ADDR);
  assign bus.m_mas_n_o = ~(st_q == ST_ADDR);
  assign bus.m_mbb_oe = (st_q == ST_ADDR) || in_txn || (st_q == ST_HOLD);
  assign bus.m_mbb_n_o = ~bus.m_mbb_oe;
  assign bus.m_mbr_n = ~(st_q == ST_REQ);

  // ==========================================================
  // cycle count after the strobe, park count, inhibit tracking
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      acnt_q <= '0;
      park_q <= '0;
      beat_q <= '0;
      mih_seen_q <= 1'b0;
    end else begin
      if (st_q == ST_ADDR) begin
        acnt_q <= 2'h1;
        beat_q <= '0;
        mih_seen_q <= 1'b0;
      end else begin
        if (acnt_q != 2'(MIH_A_CYC)) begin
          acnt_q <= 2'(acnt_q + 1'b1);
        end
        if (mih_hit) begin
          beat_q <= '0;
          mih_seen_q <= 1'b1;
        end else if (acc_beat) begin
          beat_q <= BEAT_W'(beat_q + 1'b1);
        end
      end
      if (st_q == ST_HOLD && park_q != 2'(PARK_MAX_CYC)) begin
        park_q <= 2'(park_q + 1'b1);
      end else if (st_q != ST_HOLD) begin
        park_q <= '0;
      end
    end
  end

  // ==========================================================
  // responses to the user
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      rsp_valid_o <= 1'b0;
      rsp_data_o <= '0;
      rsp_flush_o <= 1'b0;
      done_o <= 1'b0;
      done_ack_o <= ACK_IDLE;
    end else begin
      rsp_valid_o <= acc_beat & ~write_q;
      if (acc_beat) begin
        rsp_data_o <= (bus.mad >> shift) & rmask;
      end
      rsp_flush_o <= mih_hit & (beat_q != '0);
      done_o <= finish;
      if (finish) begin
        done_ack_o <= ack;
      end
    end
  end

  // ==========================================================
  // snoop: a foreign strobe at A+0, owner answers at A+1, inhibit at A+2
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      snoop_valid_o <= 1'b0;
      snoop_addr_o <= '0;
      mih_drv_q <= 1'b0;
    end else begin
      snoop_valid_o <= ~bus.mas_n & (st_q != ST_ADDR);
      if (~bus.mas_n) begin
        snoop_addr_o <= bus.mad[PA_LSB +: ADDR_W];
      end
      mih_drv_q <= snoop_valid_o & snoop_own_i;
    end
  end

  assign bus.m_mih_oe = mih_drv_q;
  assign bus.m_mih_n_o = ~mih_drv_q;
endmodule : sbt_master

// *** rtl/sbt_pkg.sv ***
// shared constants, acknowledge codes and lane helper for the bus port
// assumes one bus clock; every bus signal changes and is sampled on its rising edge
package sbt_pkg;

  // ==========================================================
  // widths and address-cycle field layout
  localparam int ADDR_W = 36;
  localparam int CTRL_W = 28;
  localparam int DATA_W = 64;
  localparam int SIZE_W = 2;
  localparam int PA_LSB = 0;
  localparam int CTRL_LSB = 36;
  localparam int BYTES_PER_DW = 8;

  // ==========================================================
  // timing counts in bus cycles: inhibit and timeout after the address strobe, park in held cycles
  localparam int MIH_A_CYC = 2;
  localparam int PARK_MAX_CYC = 2;
  localparam int TIMEOUT_CYC = 64;

  // ==========================================================
  // acknowledge: code is the inverted {error, ready, retry} triple
  typedef enum logic [2:0] {
    ACK_IDLE = 3'h0,
    ACK_RR = 3'h1,
    ACK_DATA = 3'h2,
    ACK_RSVD = 3'h3,
    ACK_BUSERR = 3'h4,
    ACK_TIMEOUT = 3'h5,
    ACK_UNCORR = 3'h6,
    ACK_RETRY = 3'h7
  } sbt_ack_t;

  // ==========================================================
  // big-endian lanes: byte 0 on bits 63:56, byte 7 on bits 7:0
  function automatic logic [5:0] sbt_lane_shift(input logic [2:0] off,
                                                input logic [SIZE_W-1:0] sz);
    logic [3:0] n;
    n = 4'h8 - {1'b0, off} - (4'h1 << sz);
    return {n[2:0], 3'h0};
  endfunction : sbt_lane_shift

endpackage : sbt_pkg

// *** rtl/sbt_bus_if.sv ***
// bus wires between a master end and the system end
// assumes pull-ups: an undriven active-low line reads high, undriven data reads zero
`timescale 1ns/1ps
interface sbt_bus_if;
  import sbt_pkg::*;

  // ==========================================================
  // master drives
  logic [DATA_W-1:0] m_mad_o;
  logic m_mad_oe;
  logic m_mas_n_o;
  logic m_mas_oe;
  logic m_mbb_n_o;
  logic m_mbb_oe;
  logic m_mih_n_o;
  logic m_mih_oe;
  logic m_mbr_n;

  // ==========================================================
  // system drives
  logic [DATA_W-1:0] s_mad_o;
  logic s_mad_oe;
  logic [2:0] s_ack_n_o;
  logic s_ack_oe;
  logic s_mbg_n;

  // ==========================================================
  // resolved line levels
  logic [DATA_W-1:0] mad;
  logic mas_n;
  logic mbb_n;
  logic mih_n;
  logic [2:0] ack_n;

  assign mad = m_mad_oe ? m_mad_o : (s_mad_oe ? s_mad_o : '0);
  assign mas_n = m_mas_oe ? m_mas_n_o : 1'b1;
  assign mbb_n = m_mbb_oe ? m_mbb_n_o : 1'b1;
  assign mih_n = m_mih_oe ? m_mih_n_o : 1'b1;
  assign ack_n = s_ack_oe ? s_ack_n_o : 3'h7;

  modport master (
    output m_mad_o, m_mad_oe, m_mas_n_o, m_mas_oe, m_mbb_n_o, m_mbb_oe,
    output m_mih_n_o, m_mih_oe, m_mbr_n,
    input mad, mas_n, mbb_n, mih_n, ack_n, s_mbg_n
  );

  modport system (
    output s_mad_o, s_mad_oe, s_ack_n_o, s_ack_oe, s_mbg_n,
    input mad, mas_n, mbb_n, mih_n, ack_n, m_mbr_n
  );
endinterface : sbt_bus_if

// *** rtl/sbt_ack_decode.sv ***
// decoder of the three active-low acknowledge lines
// assumes the lines are already resolved bus levels on the bus clock
`timescale 1ns/1ps
module sbt_ack_decode (
  // lines
  input wire logic [2:0] ack_n_i,
  // decoded
  output sbt_pkg::sbt_ack_t ack_o,
  output logic data_o,
  output logic term_o
);
  import sbt_pkg::*;

  // ==========================================================
  // decode
  assign ack_o = sbt_ack_t'(~ack_n_i);
  assign data_o = (ack_o == ACK_DATA);
  // anything but idle or data ends the transaction at once
  assign term_o = (ack_o != ACK_IDLE) && (ack_o != ACK_DATA);
endmodule : sbt_ack_decode

// *** rtl/sbt_bus_system.sv ***
// system end: arbiter for one master line, addressed slave or memory, bus monitor
// assumes the user side answers for the slave one cycle ahead of the bus
`timescale 1ns/1ps
module sbt_bus_system #(
  parameter int TIMEOUT = sbt_pkg::TIMEOUT_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // bus
  sbt_bus_if.system bus,
  // arbitration
  input wire logic other_req_i,
  // target
  output logic tgt_start_o,
  output logic tgt_busy_o,
  output logic [sbt_pkg::ADDR_W-1:0] tgt_addr_o,
  output logic [sbt_pkg::CTRL_W-1:0] tgt_ctrl_o,
  input wire sbt_pkg::sbt_ack_t tgt_ack_i,
  input wire logic tgt_last_i,
  input wire logic tgt_rdata_valid_i,
  input wire logic [sbt_pkg::DATA_W-1:0] tgt_rdata_i,
  output logic tgt_abort_o,
  output logic timeout_o
);
  import sbt_pkg::*;

  localparam int CNT_W = $clog2(TIMEOUT + 1);

  logic grant_q, busy_q, ack_oe_q, dat_oe_q;
  sbt_ack_t ack_q, ack_nx;
  logic [DATA_W-1:0] dat_q;
  logic [CNT_W-1:0] acnt_q;
  logic mih_now, tmo, nx_end;

  // ==========================================================
  // arbiter: grant stays parked until another master wants the bus
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      grant_q <= 1'b0;
    end else if (bus.mbb_n) begin
      if (~bus.m_mbr_n) begin
        grant_q <= 1'b1;
      end else if (other_req_i) begin
        grant_q <= 1'b0;
      end
    end
  end

  assign bus.s_mbg_n = ~grant_q;

  // ==========================================================
  // target answer, monitor timeout and memory abort
  assign mih_now = busy_q & ~bus.mih_n & (acnt_q >= CNT_W'(MIH_A_CYC));
  // silence from the slave until the limit: monitor answers instead
  assign tmo = busy_q & (tgt_ack_i == ACK_IDLE) & (acnt_q == CNT_W'(TIMEOUT - 1));
  assign ack_nx = tmo ? ACK_TIMEOUT : tgt_ack_i;
  assign nx_end = tmo || ((ack_nx != ACK_IDLE) && (ack_nx != ACK_DATA)) ||
                  ((ack_nx == ACK_DATA) && tgt_last_i);

  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      busy_q <= 1'b0;
      acnt_q <= '0;
      tgt_addr_o <= '0;
      tgt_ctrl_o <= '0;
      tgt_start_o <= 1'b0;
      tgt_abort_o <= 1'b0;
      timeout_o <= 1'b0;
    end else begin
      tgt_start_o <= ~bus.mas_n;
      tgt_abort_o <= mih_now;
      timeout_o <= tmo & ~mih_now;
      if (~bus.mas_n) begin
        busy_q <= 1'b1;
        acnt_q <= CNT_W'(1);
        tgt_addr_o <= bus.mad[PA_LSB +: ADDR_W];
        tgt_ctrl_o <= bus.mad[CTRL_LSB +: CTRL_W];
      end else if (mih_now || (busy_q && nx_end)) begin
        // without an inhibit memory keeps delivering to the end
        busy_q <= 1'b0;
      end else if (busy_q && acnt_q != CNT_W'(TIMEOUT)) begin
        acnt_q <= CNT_W'(acnt_q + 1'b1);
      end
    end
  end

  assign tgt_busy_o = busy_q;

  // ==========================================================
  // bus drive registers: acknowledge lines driven high when idle, released after; data lines driven only with valid read data
  always_ff @(posedge sys_clk_i or negedge rst_b_i) begin
    if (!rst_b_i) begin
      ack_q <= ACK_IDLE;
      ack_oe_q <= 1'b0;
      dat_q <= '0;
      dat_oe_q <= 1'b0;
    end else begin
      ack_oe_q <= busy_q & ~mih_now;
      if (busy_q && !mih_now) begin
        ack_q <= ack_nx;
        dat_q <= tgt_rdata_i;
        dat_oe_q <= tgt_rdata_valid_i & (ack_nx == ACK_DATA);
      end else begin
        ack_q <= ACK_IDLE;
        dat_oe_q <= 1'b0;
      end
    end
  end

  assign bus.s_ack_n_o = ~ack_q;
  assign bus.s_ack_oe = ack_oe_q;
  assign bus.s_mad_o = dat_q;
  assign bus.s_mad_oe = dat_oe_q;
endmodule : sbt_bus_system

// *** bench/sbt_bus_checker.sv ***
// checker of the shared bus lines between master end and system end
// assumes resolved interface levels on one clock, reset active low
`timescale 1ns/1ps
module sbt_bus_checker (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  // bus lines
  input wire logic mas_n,
  input wire logic mbb_n,
  input wire logic [2:0] ack_n,
  input wire logic m_mbr_n,
  input wire logic s_mbg_n
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (!rst_b_i);

  // ====
  // strobe, busy and grant
  mas_one_cycle_a: assert property (!mas_n |=> mas_n)
    else $error("strobe held past its address cycle");
  mas_busy_a: assert property (!mas_n |-> !mbb_n ##1 !mbb_n)
    else $error("busy not low at A+0 and A+1");
  ack_busy_a: assert property (ack_n != 3'h7 |-> !mbb_n)
    else $error("acknowledge outside a busy span");
  mas_grant_a: assert property (!mas_n |-> !s_mbg_n)
    else $error("strobe without grant");
  grant_req_a: assert property (!m_mbr_n && mbb_n && s_mbg_n |-> ##[1:2] !s_mbg_n)
    else $error("request on idle bus not granted");

  // ====
  // termination and retry
  term_release_a: assert property (ack_n != 3'h7 && ack_n != 3'h5 |=> ack_n == 3'h7)
    else $error("answer after terminating acknowledge");
  retry_release_a: assert property (ack_n == 3'h6 || ack_n == 3'h0 |=> mbb_n)
    else $error("busy kept after retry acknowledge");
  retry_again_a: assert property (ack_n == 3'h6 || ack_n == 3'h0 |-> ##[2:16] !mas_n)
    else $error("no fresh strobe after retry");

  cover property (!mas_n ##[2:20] ack_n == 3'h5);
  cover property (ack_n == 3'h2);
  cover property (ack_n == 3'h0);
endmodule : sbt_bus_checker

// *** bench/shared_bus_transaction_port_bench.sv ***
// self-checking bench: master end and system end joined by one bus interface
// assumes the rtl package, interface and both ends are compiled first
`timescale 1ns/1ps
module shared_bus_transaction_port_bench;
  import sbt_pkg::*;
  localparam int TMO = 8;
  // ====
  // user-side signals
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic rv = 1'b0, rw = 1'b0, rcoh = 1'b0, hold = 1'b0, oreq = 1'b0;
  logic [35:0] ra = '0;
  logic [27:0] rc = '0;
  logic [1:0] rs = '0;
  logic [2:0] rb = 3'h1;
  logic rdy, rsp_v, done, tstart, tout;
  logic [2:0] wb;
  logic [63:0] rsp_d, wd, trd = '0;
  logic [35:0] taddr;
  logic [27:0] tctrl;
  logic snp, flush, tabort;
  sbt_ack_t dack;
  sbt_ack_t tack = ACK_IDLE;
  logic tlast = 1'b0, trv = 1'b0;
  // responder setup and monitor results
  sbt_ack_t t_code = ACK_DATA, t_rcode = ACK_RR;
  int t_wait = 0, t_beats = 1, t_retries = 0, cnt = 0, beat = 0;
  logic act = 1'b0, mbb_last = 1'b1;
  int cyc = 0, a_cyc, f_cyc, n_mas, n_ack, n_mbr, n_rise, n_tout;
  int n_fail = 0, n_checks = 0, n_x = 0;
  logic [63:0] amad, wmad, rq[$];
  logic [63:0] rpat = 64'h0123_4567_89ab_cdef;
  logic [63:0] wbase = 64'hfedc_ba98_7654_3210;

  assign wd = wbase ^ 64'(wb);
  always #5 clk = ~clk;
  always @(posedge clk) cyc++;

  // ====
  // ends, wires and checker
  sbt_bus_if bus_if();
  sbt_master #(.BEAT_W(3)) sbt_master_inst (.sys_clk_i(clk), .rst_b_i(rst_b),
    .bus(bus_if.master), .req_valid_i(rv), .req_ready_o(rdy), .req_write_i(rw),
    .req_coherent_i(rcoh), .req_addr_i(ra), .req_ctrl_i(rc), .req_size_i(rs),
    .req_beats_i(rb), .hold_bus_i(hold), .wr_data_i(wd), .wr_beat_o(wb),
    .rsp_valid_o(rsp_v), .rsp_data_o(rsp_d), .rsp_flush_o(flush), .done_o(done),
    .done_ack_o(dack), .snoop_valid_o(snp), .snoop_addr_o(), .snoop_own_i(1'b0));
  sbt_bus_system #(.TIMEOUT(TMO)) sbt_bus_system_inst (.sys_clk_i(clk), .rst_b_i(rst_b),
    .bus(bus_if.system), .other_req_i(oreq), .tgt_start_o(tstart), .tgt_busy_o(),
    .tgt_addr_o(taddr), .tgt_ctrl_o(tctrl), .tgt_ack_i(tack), .tgt_last_i(tlast),
    .tgt_rdata_valid_i(trv), .tgt_rdata_i(trd), .tgt_abort_o(tabort), .timeout_o(tout));
  sbt_bus_checker sbt_bus_checker_inst (.sys_clk_i(clk), .rst_b_i(rst_b),
    .mas_n(bus_if.mas_n), .mbb_n(bus_if.mbb_n), .ack_n(bus_if.ack_n),
    .m_mbr_n(bus_if.m_mbr_n), .s_mbg_n(bus_if.s_mbg_n));

  // ====
  // slave answers, one cycle ahead of the bus; retries first, then the t_code answer
  always @(negedge clk) begin
    tack <= ACK_IDLE;
    tlast <= 1'b0;
    trv <= 1'b0;
    if (tstart) begin
      act = 1'b1;
      cnt = 0;
      beat = 0;
    end
    if (act && cnt >= t_wait) begin
      if (t_retries > 0) begin
        tack <= t_rcode;
        t_retries--;
        act = 1'b0;
      end else begin
        tack <= t_code;
        tlast <= (beat == t_beats - 1);
        // read data only: on a write the master owns the data lines
        trv <= !rw;
        trd <= rpat ^ 64'(beat);
        beat++;
        act = (t_code == ACK_DATA) && (beat < t_beats);
      end
    end
    cnt++;
  end

  // bus monitor, sampled mid-cycle where lines are settled
  always @(negedge clk) begin
    if (!bus_if.mas_n) begin
      n_mas++;
      a_cyc = cyc;
      amad = bus_if.mad;
    end
    if (bus_if.ack_n != 3'h7) begin
      n_ack++;
      if (n_ack == 1) f_cyc = cyc;
      if (bus_if.ack_n == 3'h5) wmad = bus_if.mad;
    end
    if (!bus_if.m_mbr_n && bus_if.mas_n && bus_if.mbb_n) n_mbr++;
    if (bus_if.mbb_n && !mbb_last) n_rise++;
    mbb_last = bus_if.mbb_n;
    if (rsp_v) rq.push_back(rsp_d);
    if (tout) n_tout++;
    if (snp || flush || tabort) n_x++;
  end

  // ====
  // shared tasks
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic txn(input logic w, input logic coh, input logic [35:0] a,
                     input logic [1:0] s, input logic [2:0] nb);
    int k;
    n_mas = 0;
    n_ack = 0;
    n_mbr = 0;
    n_tout = 0;
    n_x = 0;
    rq.delete();
    @(negedge clk);
    rv = 1'b1;
    rw = w;
    rcoh = coh;
    ra = a;
    rs = s;
    rb = nb;
    rc = {a[11:8], 24'h5e1c3a};
    for (k = 0; k < 50 && rdy !== 1'b1; k++) @(negedge clk);
    @(negedge clk);
    rv = 1'b0;
    for (k = 0; k < 300 && done !== 1'b1; k++) @(negedge clk);
    #1;
    chk(64'(k < 300), 64'h1);
    chk(64'(n_x), 64'h0);
    chk(64'(tctrl), 64'(rc));
    chk(64'(amad[35:0]), 64'(a));
    chk(64'(amad[63:36]), 64'(rc));
    chk(64'(taddr), 64'(a));
  endtask : txn

  // ====
  // scenarios
  task automatic t_lanes();
    int offs[5] = '{6, 2, 0, 4, 0};
    int szs[5] = '{0, 1, 2, 2, 3};
    logic [63:0] m;
    int sh;
    for (int w = 0; w < 2; w++) begin
      for (int i = 0; i < 5; i++) begin
        sh = (8 - offs[i] - (1 << szs[i])) * 8;
        m = (szs[i] == 3) ? '1 : (64'h1 << (8 << szs[i])) - 64'h1;
        txn(w[0], 1'b0, 36'h9abcd1230 | 36'(offs[i]), 2'(szs[i]), 3'h1);
        chk(64'(dack), 64'(ACK_DATA));
        if (w == 1) chk(wmad & (m << sh), (wbase & m) << sh);
        else chk(rq[0], (rpat >> sh) & m);
      end
    end
  endtask : t_lanes

  task automatic t_burst();
    t_beats = 4;
    t_wait = 2;
    txn(1'b0, 1'b1, 36'h000000400, 2'h3, 3'h4);
    chk(64'(f_cyc - a_cyc), 64'h4);
    chk(64'(n_ack), 64'h4);
    chk(64'(rq.size()), 64'h4);
    foreach (rq[i]) chk(rq[i], rpat ^ 64'(i));
    t_beats = 1;
    t_wait = 0;
  endtask : t_burst

  task automatic t_errors();
    sbt_ack_t codes[3] = '{ACK_BUSERR, ACK_UNCORR, ACK_RSVD};
    t_beats = 4;
    foreach (codes[i]) begin
      t_code = codes[i];
      txn(1'b0, 1'b0, 36'h000000100, 2'h3, 3'h4);
      chk(64'(n_ack), 64'h1);
      if (codes[i] != ACK_RSVD) chk(64'(dack), 64'(codes[i]));
    end
    t_code = ACK_DATA;
    t_beats = 1;
  endtask : t_errors

  task automatic t_retry();
    sbt_ack_t codes[2] = '{ACK_RR, ACK_RETRY};
    foreach (codes[i]) begin
      t_rcode = codes[i];
      t_retries = 1;
      txn(1'b0, 1'b0, 36'h000000300, 2'h3, 3'h1);
      chk(64'(n_mas), 64'h2);
      chk(64'(n_mbr != 0), 64'h1);
      chk(64'(dack), 64'(ACK_DATA));
      chk(rq[0], rpat);
    end
  endtask : t_retry

  task automatic t_timeout();
    t_code = ACK_IDLE;
    txn(1'b0, 1'b0, 36'h000000200, 2'h3, 3'h1);
    chk(64'(f_cyc - a_cyc), 64'(TMO));
    chk(64'(dack), 64'(ACK_TIMEOUT));
    chk(64'(n_tout), 64'h1);
    t_code = ACK_DATA;
  endtask : t_timeout

  task automatic t_hold();
    hold = 1'b1;
    n_rise = 0;
    txn(1'b0, 1'b0, 36'h000000500, 2'h3, 3'h1);
    txn(1'b1, 1'b0, 36'h000000508, 2'h3, 3'h1);
    chk(64'(n_rise), 64'h0);
    repeat (2) @(negedge clk);
    chk(64'(bus_if.mbb_n), 64'h1);
    hold = 1'b0;
  endtask : t_hold

  task automatic t_arb();
    oreq = 1'b1;
    repeat (4) @(negedge clk);
    chk(64'(bus_if.s_mbg_n), 64'h1);
    txn(1'b0, 1'b0, 36'h000000600, 2'h3, 3'h1);
    chk(64'(n_mbr != 0), 64'h1);
    chk(64'(dack), 64'(ACK_DATA));
    oreq = 1'b0;
  endtask : t_arb

  // ====
  // verdict, sequence and watchdog
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : tally_and_finish

  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    t_lanes();
    t_burst();
    t_errors();
    t_retry();
    t_timeout();
    t_hold();
    t_arb();
    tally_and_finish();
  end

  // the sequence needs well under a thousand cycles
  initial begin
    #200000;
    n_fail++;
    tally_and_finish();
  end
endmodule : shared_bus_transaction_port_bench
